// File: hdl/pcd_pkg.sv
package pcd_pkg;

    // Bus and register map.
    localparam int          DATA_W               = 32;
    localparam int          ADDR_W               = 12;
    localparam logic [11:0] OFF_CONFIG_WORD      = 12'h000;
    localparam logic [11:0] OFF_DECODED_RATIOS   = 12'h004;
    localparam logic [11:0] OFF_STATUS           = 12'h008;

    // Configuration word field positions.
    localparam int          ODIV_LSB             = 16;
    localparam int          USB_BYPASS_BIT       = 15;
    localparam int          UIDIV_LSB            = 8;
    localparam int          MUL_LSB              = 4;
    localparam int          IDIV_LSB             = 0;
    localparam int          SEL_W                = 3;

    // Reserved positions that must be programmed to one.
    localparam logic [31:0] RSVD_MASK            = 32'hFFF8_7888;

    // Decoded ratio register field positions.
    localparam int          RAT_ODIV_LSB         = 0;
    localparam int          RAT_MUL_LSB          = 16;
    localparam int          RAT_UIDIV_LSB        = 24;

    // Status register bit positions.
    localparam int          ST_VALID_BIT         = 0;
    localparam int          ST_RSVD_ERR_BIT      = 1;
    localparam int          ST_USB_BIT           = 2;

    // Reset value of the captured word: all ones, the erased state.
    localparam logic [31:0] CONFIG_WORD_RESET    = 32'hFFFF_FFFF;

endpackage : pcd_pkg

// File: hdl/pcd_field_decode.sv
`timescale 1ns/10ps
module pcd_field_decode
    import pcd_pkg::*;
(
    input  wire logic [31:0] i_word,
    input  wire logic        i_usb_present,
    output logic      [8:0]  o_out_div,
    output logic      [4:0]  o_mul,
    output logic      [3:0]  o_usb_in_div,
    output logic             o_usb_bypass
);

    logic [2:0] odiv_sel;
    logic [2:0] mul_sel;
    logic [2:0] uidiv_sel;

    assign odiv_sel  = i_word[ODIV_LSB +: SEL_W];
    assign mul_sel   = i_word[MUL_LSB +: SEL_W];
    assign uidiv_sel = i_word[UIDIV_LSB +: SEL_W];

    always_comb begin
        unique case (odiv_sel)
            3'h0: o_out_div = 9'h001;
            3'h1: o_out_div = 9'h002;
            3'h2: o_out_div = 9'h004;
            3'h3: o_out_div = 9'h008;
            3'h4: o_out_div = 9'h010;
            3'h5: o_out_div = 9'h020;
            3'h6: o_out_div = 9'h040;
            3'h7: o_out_div = 9'h100;
        endcase
    end

    always_comb begin
        unique case (mul_sel)
            3'h0: o_mul = 5'h0F;
            3'h1: o_mul = 5'h10;
            3'h2: o_mul = 5'h11;
            3'h3: o_mul = 5'h12;
            3'h4: o_mul = 5'h13;
            3'h5: o_mul = 5'h14;
            3'h6: o_mul = 5'h15;
            3'h7: o_mul = 5'h18;
        endcase
    end

    // USB input divider table, only with USB present.
    always_comb begin
        if (!i_usb_present) begin
            o_usb_in_div = 4'h1;
        end else begin
            unique case (uidiv_sel)
                3'h0: o_usb_in_div = 4'h1;
                3'h1: o_usb_in_div = 4'h2;
                3'h2: o_usb_in_div = 4'h3;
                3'h3: o_usb_in_div = 4'h4;
                3'h4: o_usb_in_div = 4'h5;
                3'h5: o_usb_in_div = 4'h6;
                3'h6: o_usb_in_div = 4'hA;
                3'h7: o_usb_in_div = 4'hC;
            endcase
        end
    end

    // One bypasses the USB PLL, forced without USB.
    assign o_usb_bypass = i_usb_present ? i_word[USB_BYPASS_BIT] : 1'b1;

endmodule : pcd_field_decode

// File: hdl/pcd_top.sv
// Function
// - Output divisor code maps to 1..256.
// - Bit 15 one bypasses USB PLL.
// - USB input divider code maps to 1..12.
// - Multiplier code maps to 15..24.
// - USB fields are decoded only with USB; the USB divider select passes raw.
`timescale 1ns/10ps
module pcd_top
    import pcd_pkg::*;
#(
    parameter bit USB_PRESENT = 1'b1
)
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset_n,
    input  wire logic [31:0]       i_nv_config_word,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    output logic      [2:0]        o_pll_output_divisor_sel,
    output logic      [2:0]        o_pll_multiplier_sel,
    output logic      [2:0]        o_pll_input_div_sel,
    output logic      [2:0]        o_usb_pll_input_div_sel,
    output logic                   o_usb_pll_bypass,
    output logic      [8:0]        o_pll_out_div,
    output logic      [4:0]        o_pll_mul,
    output logic      [3:0]        o_usb_pll_in_div,
    output logic                   o_config_valid
);

    // Pin synchroniser and capture.
    logic [31:0] word_s1_q;
    logic [31:0] word_s1_d;
    logic [31:0] word_s2_q;
    logic [31:0] word_s2_d;
    logic [1:0]  cap_cnt_q;
    logic [1:0]  cap_cnt_d;
    logic [31:0] config_word_q;
    logic [31:0] config_word_d;
    logic        valid_q;
    logic        valid_d;
    logic        rsvd_err_q;
    logic        rsvd_err_d;

    // Decoded ratios held in registers.
    logic [8:0]  out_div_c;
    logic [4:0]  mul_c;
    logic [3:0]  usb_in_div_c;
    logic        usb_bypass_c;
    logic [8:0]  out_div_q;
    logic [8:0]  out_div_d;
    logic [4:0]  mul_q;
    logic [4:0]  mul_d;
    logic [3:0]  usb_in_div_q;
    logic [3:0]  usb_in_div_d;
    logic        usb_bypass_q;
    logic        usb_bypass_d;

    // Bus slave state.
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [31:0] rd_mux;
    logic        addr_hit;

    always_comb begin
        word_s1_d     = i_nv_config_word;
        word_s2_d     = word_s1_q;
        cap_cnt_d     = cap_cnt_q;
        config_word_d = config_word_q;
        valid_d       = valid_q;
        rsvd_err_d    = rsvd_err_q;
        if (!valid_q) begin
            if (cap_cnt_q == 2'h2) begin
                config_word_d = word_s2_q;
                valid_d       = 1'b1;
                rsvd_err_d    = ((word_s2_q & RSVD_MASK) != RSVD_MASK);
            end else begin
                cap_cnt_d = cap_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        word_s1_q <= word_s1_d;
        word_s2_q <= word_s2_d;
        if (!i_reset_n) begin
            cap_cnt_q     <= 2'h0;
            config_word_q <= CONFIG_WORD_RESET;
            valid_q       <= 1'b0;
            rsvd_err_q    <= 1'b0;
        end else begin
            cap_cnt_q     <= cap_cnt_d;
            config_word_q <= config_word_d;
            valid_q       <= valid_d;
            rsvd_err_q    <= rsvd_err_d;
        end
    end

    pcd_field_decode u_decode (
        .i_word        (config_word_q),
        .i_usb_present (USB_PRESENT),
        .o_out_div     (out_div_c),
        .o_mul         (mul_c),
        .o_usb_in_div  (usb_in_div_c),
        .o_usb_bypass  (usb_bypass_c)
    );

    always_comb begin
        out_div_d    = out_div_c;
        mul_d        = mul_c;
        usb_in_div_d = usb_in_div_c;
        usb_bypass_d = usb_bypass_c;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            out_div_q    <= 9'h001;
            mul_q        <= 5'h18;
            usb_in_div_q <= 4'hC;
            usb_bypass_q <= 1'b1;
        end else begin
            out_div_q    <= out_div_d;
            mul_q        <= mul_d;
            usb_in_div_q <= usb_in_div_d;
            usb_bypass_q <= usb_bypass_d;
        end
    end

    always_comb begin
        addr_hit = 1'b1;
        unique case (i_paddr)
            OFF_CONFIG_WORD: begin
                rd_mux = config_word_q;
            end
            OFF_DECODED_RATIOS: begin
                rd_mux                         = 32'h0000_0000;
                rd_mux[RAT_ODIV_LSB +: 9]      = out_div_q;
                rd_mux[RAT_MUL_LSB +: 5]       = mul_q;
                rd_mux[RAT_UIDIV_LSB +: 4]     = usb_in_div_q;
            end
            OFF_STATUS: begin
                rd_mux                  = 32'h0000_0000;
                rd_mux[ST_VALID_BIT]    = valid_q;
                rd_mux[ST_RSVD_ERR_BIT] = rsvd_err_q;
                rd_mux[ST_USB_BIT]      = USB_PRESENT;
            end
            default: begin
                rd_mux   = 32'h0000_0000;
                addr_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        prdata_d  = 32'h0000_0000;
        if (i_psel && i_penable && !pready_q) begin
            pready_d = 1'b1;
            if (i_pwrite || !addr_hit) begin
                pslverr_d = 1'b1;
            end else begin
                prdata_d = rd_mux;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    assign o_prdata                 = prdata_q;
    assign o_pready                 = pready_q;
    assign o_pslverr                = pslverr_q;
    assign o_pll_output_divisor_sel = config_word_q[ODIV_LSB +: SEL_W];
    assign o_pll_multiplier_sel     = config_word_q[MUL_LSB +: SEL_W];
    assign o_pll_input_div_sel      = config_word_q[IDIV_LSB +: SEL_W];
    assign o_usb_pll_input_div_sel  = config_word_q[UIDIV_LSB +: SEL_W];
    assign o_usb_pll_bypass         = usb_bypass_q;
    assign o_pll_out_div            = out_div_q;
    assign o_pll_mul                = mul_q;
    assign o_usb_pll_in_div         = usb_in_div_q;
    assign o_config_valid           = valid_q;

endmodule : pcd_top

// File: test/pcd_checker.sv
`timescale 1ns/10ps
module pcd_checker
    import pcd_pkg::*;
#(
    parameter bit USB_PRESENT = 1'b1
)
(
    input wire logic        i_ref_clk,
    input wire logic        i_reset_n,
    input wire logic [31:0] i_nv_config_word,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [2:0]  o_pll_output_divisor_sel,
    input wire logic [2:0]  o_pll_multiplier_sel,
    input wire logic [2:0]  o_usb_pll_input_div_sel,
    input wire logic        o_usb_pll_bypass,
    input wire logic [8:0]  o_pll_out_div,
    input wire logic [4:0]  o_pll_mul,
    input wire logic [3:0]  o_usb_pll_in_div,
    input wire logic        o_config_valid
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    logic [2:0] od;
    logic [2:0] ml;
    logic [2:0] ud;
    assign od = o_pll_output_divisor_sel;
    assign ml = o_pll_multiplier_sel;
    assign ud = o_usb_pll_input_div_sel;
    odiv_map_a: assert property (o_config_valid && $past(o_config_valid, 2) |->
        o_pll_out_div == ((od == 3'h7) ? 9'h100 : 9'h001 << od)) else $error("bad divisor");
    mul_map_a: assert property (o_config_valid && $past(o_config_valid, 2) |->
        o_pll_mul == ((ml == 3'h7) ? 5'h18 : 5'h0F + ml)) else $error("bad multiplier");
    usb_div_map_a: assert property (o_config_valid && $past(o_config_valid, 2) |->
        o_usb_pll_in_div == (!USB_PRESENT ? 4'h1 : (ud < 3'h6) ? 4'h1 + ud
        : (ud == 3'h6) ? 4'hA : 4'hC)) else $error("bad usb divider");
    bypass_map_a: assert property ($rose(o_config_valid) |-> ##2
        o_usb_pll_bypass == ($past(i_nv_config_word[15], 3) || !USB_PRESENT))
        else $error("bad usb bypass");
    sel_capture_a: assert property ($rose(o_config_valid) |-> {od, ml, ud} ==
        {$past(i_nv_config_word[18:16]), $past(i_nv_config_word[6:4]),
        $past(i_nv_config_word[10:8])}) else $error("bad capture");
    cfg_hold_a: assert property (o_config_valid && $past(o_config_valid, 2) |->
        $stable({od, ml, ud, o_usb_pll_bypass, o_pll_out_div})) else $error("config moved");
    ready_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("no ready");
    ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready too long");
    write_err_a: assert property (o_pready && i_pwrite |-> o_pslverr) else $error("write ok");
    read_idle_a: assert property (!o_pready |-> o_prdata == 32'h0) else $error("stray data");
    cover property (o_pready && i_pwrite);
    cover property (o_pready && !o_pslverr);
    cover property ($rose(o_config_valid));
endmodule : pcd_checker
bind pcd_top pcd_checker #(.USB_PRESENT(USB_PRESENT)) checker_i (.i_ref_clk, .i_reset_n,
    .i_nv_config_word, .i_psel, .i_penable, .i_pwrite, .o_prdata, .o_pready, .o_pslverr,
    .o_pll_output_divisor_sel, .o_pll_multiplier_sel, .o_usb_pll_input_div_sel,
    .o_usb_pll_bypass, .o_pll_out_div, .o_pll_mul, .o_usb_pll_in_div, .o_config_valid);

// File: test/pcd_clk_model.sv
`timescale 1ns/10ps
module pcd_clk_model
(
    input  wire logic [8:0] i_pll_out_div,
    input  wire logic [4:0] i_pll_mul,
    input  wire logic       i_usb_pll_bypass,
    output logic            o_usb_active,
    output logic [13:0]     o_gain
);
    assign o_usb_active = !i_usb_pll_bypass;
    assign o_gain = 14'(i_pll_mul) * 14'(i_pll_out_div);
endmodule : pcd_clk_model

// File: test/pll_config_word_decode_bench.sv
`timescale 1ns/10ps
module pll_config_word_decode_bench;
    import pcd_pkg::*;
    logic        i_ref_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic [31:0] word = 32'hFFFF_FFFF;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] prdata, rd, w, dec;
    logic        pready, pslverr, err, usb_active, byp, valid;
    logic [2:0]  odiv_s, mul_s, idiv_s, uidiv_s, s;
    logic [8:0]  odiv;
    logic [4:0]  mul;
    logic [3:0]  uidiv;
    logic [17:0] r;
    int          n_mismatch = 0, compares = 0, cyc = 0;
    pcd_top dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_nv_config_word(word),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(32'h0000_0000), .i_pstrb(4'hF), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_pll_output_divisor_sel(odiv_s), .o_pll_multiplier_sel(mul_s),
        .o_pll_input_div_sel(idiv_s), .o_usb_pll_input_div_sel(uidiv_s),
        .o_usb_pll_bypass(byp), .o_pll_out_div(odiv), .o_pll_mul(mul),
        .o_usb_pll_in_div(uidiv), .o_config_valid(valid));
    pcd_clk_model model (.i_pll_out_div(odiv), .i_pll_mul(mul), .i_usb_pll_bypass(byp),
        .o_usb_active(usb_active), .o_gain());
    initial begin
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    function automatic logic [17:0] ratios(input logic [2:0] k);
        return {(k == 3'h7) ? 9'h100 : 9'h001 << k, (k == 3'h7) ? 5'h18 : 5'h0F + k,
            (k > 3'h5) ? ((k == 3'h6) ? 4'hA : 4'hC) : 4'h1 + k};
    endfunction : ratios
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic wr, input logic [11:0] a);
        @(posedge i_ref_clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        @(posedge i_ref_clk);
        pen <= 1'b1;
        do @(posedge i_ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task wrap_up;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            wrap_up;
        end
    end
    initial begin
        for (int k = 0; k < 8; k++) begin
            s = 3'(k);
            w = RSVD_MASK | 32'(k * 32'h0001_0101) | 32'(k << MUL_LSB);
            w[USB_BYPASS_BIT] = s[0];
            w[3] = (k != 2);
            r = ratios(s);
            dec = {4'h0, r[3:0], 3'h0, r[8:4], 7'h0, r[17:9]};
            @(posedge i_ref_clk);
            word <= w;
            i_reset_n <= 1'b0;
            repeat (12) @(posedge i_ref_clk);
            i_reset_n <= 1'b1;
            repeat (6) @(posedge i_ref_clk);
            word <= ~w;
            apb(1'b1, OFF_CONFIG_WORD);
            chk({31'h0, err}, 32'h1);
            apb(1'b0, OFF_CONFIG_WORD);
            chk(rd, w);
            chk({31'h0, err}, 32'h0);
            apb(1'b0, OFF_DECODED_RATIOS);
            chk(rd, dec);
            apb(1'b0, OFF_STATUS);
            chk(rd, {29'h0, 1'b1, k == 2, 1'b1});
            chk({20'h0, odiv_s, mul_s, uidiv_s, idiv_s}, {20'h0, s, s, s, s});
            chk({13'h0, odiv, mul, uidiv, byp}, {13'h0, r, s[0]});
            chk({31'h0, valid}, 32'h1);
            chk({31'h0, usb_active}, {31'h0, !s[0]});
            apb(1'b0, 12'h00C);
            chk({31'h0, err}, 32'h1);
            chk(rd, 32'h0);
        end
        wrap_up;
    end
endmodule : pll_config_word_decode_bench
